// File: src/sdcc_map.vh
`ifndef SDCC_MAP_VH
`define SDCC_MAP_VH
// register byte offsets
`define SDCC_CTRL 8'h00
`define SDCC_PWREN 8'h04
`define SDCC_CLOCK_DIVIDER 8'h08
`define SDCC_CLOCK_SOURCE_SELECT 8'h0C
`define SDCC_CLKGATE 8'h10
`define SDCC_WIDTH 8'h18
`define SDCC_ARG 8'h28
`define SDCC_CMD 8'h2C
`define SDCC_RESP0 8'h30
`define SDCC_RESP1 8'h34
`define SDCC_RESP2 8'h38
`define SDCC_RESP3 8'h3C
`define SDCC_RAW 8'h44
`define SDCC_STATUS 8'h48
// command word fields
`define SDCC_C_IDX 5:0
`define SDCC_C_REXP 6
`define SDCC_C_RLONG 7
`define SDCC_C_CRC 8
`define SDCC_C_HOLD 13
`define SDCC_C_ABORT 14
`define SDCC_C_INIT 15
`define SDCC_C_UPD 21
`define SDCC_C_START 31
// raw status bits
`define SDCC_R_RTO 1
`define SDCC_R_DONE 2
`define SDCC_R_RERR 6
`define SDCC_R_RCRC 8
`define SDCC_R_LQE 12
// other fields
`define SDCC_ST_BUSY 9
`define SDCC_W_4 0
`define SDCC_W_8 16
`define SDCC_G_EN 0
`define SDCC_G_LP 16
// timing and counts in card clocks, then the 32-bit reset value
`define SDCC_LP_IDLE 4'h8
`define SDCC_RESP_TO 8'h64
`define SDCC_INIT_LEN 8'h50
`define SDCC_SHORT_LEN 8'h30
`define SDCC_LONG_LEN 8'h88
`define SDCC_RST32 32'h00000000
`endif

// File: src/sdcc_core.v
// Operation
// - width bits cleared give single bit bus
// - divider zero low byte, base/(2*div)
// - supply bits to pins, power enable
// - four dividers, source select, clock gate
// - low power stops idle clock after 9
// - clock regs load on update launch only
// - clock update raises no finished flag
// - command built from word and argument
// - finished on any reply or timeout
// - short reply word0, long fills four
// - long select and reply expected bits
// - init prefix and abort flag, default 0
// - hold waits for data command end
// - optional reply CRC check
// - launch cleared, one queued, third locks
// - timeout, crc, error status bits
// - clock update pending shows as busy
`timescale 1ns/10ps
`default_nettype none
`include "sdcc_map.vh"
module sdcc_core #(
  parameter RESP_TO = `SDCC_RESP_TO
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire data_busy,
  input wire cmd_in,
  output reg cmd_out,
  output reg cmd_oe,
  output reg cclk_out,
  output wire [1:0] supply_sel,
  output wire power_en,
  output wire [1:0] bus_width
);
////////////////////////////////////////////////////////////
localparam S_IDLE = 5'b00001;
localparam S_INIT = 5'b00010;
localparam S_SEND = 5'b00100;
localparam S_RWAIT = 5'b01000;
localparam S_RECV = 5'b10000;
function [6:0] crc_step;
  input [6:0] c;
  input b;
  reg fb;
  begin
    fb = b ^ c[6];
    crc_step = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
  end
endfunction
function [6:0] crc40;
  input [39:0] d;
  integer i;
  reg [6:0] c;
  begin
    c = 7'h00;
    for (i = 39; i >= 0; i = i - 1) begin
      c = crc_step(c, d[i]);
    end
    crc40 = c;
  end
endfunction
////////////////////////////////////////////////////////////
reg [31:0] ctrl;
reg [31:0] pwren;
reg [31:0] clock_divider;
reg [31:0] clock_source_select;
reg [31:0] clkgate;
reg [31:0] width;
reg [31:0] arg;
reg [31:0] cmdw;
reg [31:0] resp0;
reg [31:0] resp1;
reg [31:0] resp2;
reg [31:0] resp3;
reg [31:0] raw;
reg [31:0] act_div;
reg [1:0] act_src;
reg act_en;
reg act_lp;
reg [4:0] state;
reg cmd_m;
reg cmd_s;
reg [7:0] cnt [0:3];
reg [3:0] ph;
reg [3:0] idle;
reg [47:0] tx_sr;
reg [7:0] bit_cnt;
reg [7:0] to_cnt;
reg [135:0] rx_sr;
reg [6:0] rx_crc;
reg r_long;
reg r_exp;
reg r_chk;
reg [31:0] next_raw;
wire [7:0] div_sel;
wire tick;
wire rise;
wire fall;
wire clk_on;
wire pend;
wire take;
wire w_cmd;
wire lock;
wire [7:0] rx_len;
wire crc_en;
wire last_rx;
wire [135:0] rx_nx;
wire [6:0] crc_nx;
assign supply_sel = ctrl[1:0];
assign power_en = pwren[0];
assign bus_width = width[`SDCC_W_8] ? 2'h2 : (width[`SDCC_W_4] ? 2'h1 : 2'h0);
////////////////////////////////////////////////////////////
// clock dividers: half period is div base clocks, div 0 gives one
always @(posedge clk or negedge rstn) begin : divs
  integer k;
  if (!rstn) begin
    for (k = 0; k < 4; k = k + 1) begin
      cnt[k] <= 8'h00;
    end
    ph <= 4'h0;
  end else begin
    for (k = 0; k < 4; k = k + 1) begin
      if (cnt[k] + 8'h01 >= act_div[8*k +: 8]) begin
        cnt[k] <= 8'h00;
        ph[k] <= ~ph[k];
      end else begin
        cnt[k] <= cnt[k] + 8'h01;
      end
    end
  end
end
assign div_sel = act_div[8*act_src +: 8];
assign tick = (cnt[act_src] + 8'h01 >= div_sel);
assign rise = tick & ~ph[act_src] & clk_on;
assign fall = tick & ph[act_src] & clk_on;
assign clk_on = act_en & ~(act_lp & (idle > `SDCC_LP_IDLE) & (state == S_IDLE) & ~pend);
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    idle <= 4'h0;
    cclk_out <= 1'b0;
  end else begin
    cclk_out <= ph[act_src] & clk_on;
    if (state != S_IDLE || pend) begin
      idle <= 4'h0;
    end else if (tick & ~ph[act_src] & idle <= `SDCC_LP_IDLE) begin
      idle <= idle + 4'h1;
    end
  end
end
////////////////////////////////////////////////////////////
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    cmd_m <= 1'b1;
    cmd_s <= 1'b1;
  end else begin
    cmd_m <= cmd_in;
    cmd_s <= cmd_m;
  end
end
assign pend = cmdw[`SDCC_C_START];
assign w_cmd = wr_en && addr == `SDCC_CMD;
assign lock = w_cmd & wdata[`SDCC_C_START] & pend;
assign take = pend & (state == S_IDLE) &
  (~cmdw[`SDCC_C_HOLD] | ~data_busy | cmdw[`SDCC_C_ABORT]);
////////////////////////////////////////////////////////////
// register writes
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    ctrl <= `SDCC_RST32;
    pwren <= `SDCC_RST32;
    clock_divider <= `SDCC_RST32;
    clock_source_select <= `SDCC_RST32;
    clkgate <= `SDCC_RST32;
    width <= `SDCC_RST32;
    arg <= `SDCC_RST32;
    cmdw <= `SDCC_RST32;
    act_div <= `SDCC_RST32;
    act_src <= 2'h0;
    act_en <= 1'b0;
    act_lp <= 1'b0;
  end else begin
    if (wr_en) begin
      case (addr)
        `SDCC_CTRL: ctrl <= wdata;
        `SDCC_PWREN: pwren <= wdata;
        `SDCC_CLOCK_DIVIDER: clock_divider <= wdata;
        `SDCC_CLOCK_SOURCE_SELECT: clock_source_select <= wdata;
        `SDCC_CLKGATE: clkgate <= wdata;
        `SDCC_WIDTH: width <= wdata;
        `SDCC_ARG: arg <= wdata;
        default: ;
      endcase
    end
    if (w_cmd & ~lock) begin
      cmdw <= wdata;
    end else if (take) begin
      cmdw[`SDCC_C_START] <= 1'b0;
    end
    if (take & cmdw[`SDCC_C_UPD]) begin
      act_div <= clock_divider;
      act_src <= clock_source_select[1:0];
      act_en <= clkgate[`SDCC_G_EN];
      act_lp <= clkgate[`SDCC_G_LP];
    end
  end
end
////////////////////////////////////////////////////////////
// command engine
assign rx_len = r_long ? `SDCC_LONG_LEN : `SDCC_SHORT_LEN;
assign last_rx = (bit_cnt == rx_len - 8'h01);
assign crc_en = r_long ? (bit_cnt >= 8'h08 && bit_cnt < 8'h80) : (bit_cnt < 8'h28);
assign rx_nx = {rx_sr[134:0], cmd_s};
assign crc_nx = crc_en ? crc_step(rx_crc, cmd_s) : rx_crc;
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    state <= S_IDLE;
    tx_sr <= 48'h000000000000;
    bit_cnt <= 8'h00;
    to_cnt <= 8'h00;
    rx_sr <= 136'h0;
    rx_crc <= 7'h00;
    r_long <= 1'b0;
    r_exp <= 1'b0;
    r_chk <= 1'b0;
    cmd_out <= 1'b1;
    cmd_oe <= 1'b0;
  end else begin
    case (state)
      S_IDLE: begin
        bit_cnt <= 8'h00;
        if (take & ~cmdw[`SDCC_C_UPD]) begin
          tx_sr <= {2'h1, cmdw[`SDCC_C_IDX], arg,
            crc40({2'h1, cmdw[`SDCC_C_IDX], arg}), 1'b1};
          r_long <= cmdw[`SDCC_C_RLONG];
          r_exp <= cmdw[`SDCC_C_REXP];
          r_chk <= cmdw[`SDCC_C_CRC];
          state <= cmdw[`SDCC_C_INIT] ? S_INIT : S_SEND;
        end
      end
      S_INIT: begin
        if (fall) begin
          cmd_oe <= 1'b1;
          cmd_out <= 1'b1;
          bit_cnt <= bit_cnt + 8'h01;
          if (bit_cnt == `SDCC_INIT_LEN - 8'h01) begin
            bit_cnt <= 8'h00;
            state <= S_SEND;
          end
        end
      end
      S_SEND: begin
        if (fall) begin
          if (bit_cnt == `SDCC_SHORT_LEN) begin
            cmd_oe <= 1'b0;
            cmd_out <= 1'b1;
            bit_cnt <= 8'h00;
            to_cnt <= 8'h00;
            state <= r_exp ? S_RWAIT : S_IDLE;
          end else begin
            cmd_oe <= 1'b1;
            cmd_out <= tx_sr[47];
            tx_sr <= {tx_sr[46:0], 1'b1};
            bit_cnt <= bit_cnt + 8'h01;
          end
        end
      end
      S_RWAIT: begin
        if (rise) begin
          to_cnt <= to_cnt + 8'h01;
          if (!cmd_s) begin
            rx_sr <= rx_nx;
            rx_crc <= crc_step(7'h00, 1'b0);
            bit_cnt <= 8'h01;
            state <= S_RECV;
          end else if (to_cnt == RESP_TO[7:0] - 8'h01) begin
            state <= S_IDLE;
          end
        end
      end
      S_RECV: begin
        if (rise) begin
          rx_sr <= rx_nx;
          rx_crc <= crc_nx;
          bit_cnt <= bit_cnt + 8'h01;
          if (last_rx) begin
            state <= S_IDLE;
          end
        end
      end
      default: state <= S_IDLE;
    endcase
  end
end
////////////////////////////////////////////////////////////
// reply capture and status
wire fin_rx = (state == S_RECV) & rise & last_rx;
wire fin_to = (state == S_RWAIT) & rise & cmd_s & (to_cnt == RESP_TO[7:0] - 8'h01);
wire fin_nr = (state == S_SEND) & fall & (bit_cnt == `SDCC_SHORT_LEN) & ~r_exp;
wire bad_crc = r_chk & (rx_crc != rx_nx[7:1]);
wire bad_frm = ~rx_nx[0] | (r_long ? rx_nx[134] : rx_nx[46]);
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    resp0 <= `SDCC_RST32;
    resp1 <= `SDCC_RST32;
    resp2 <= `SDCC_RST32;
    resp3 <= `SDCC_RST32;
  end else if (fin_rx) begin
    if (r_long) begin
      resp0 <= rx_nx[31:0];
      resp1 <= rx_nx[63:32];
      resp2 <= rx_nx[95:64];
      resp3 <= rx_nx[127:96];
    end else begin
      resp0 <= rx_nx[39:8];
    end
  end
end
always @* begin
  next_raw = raw;
  if (wr_en && addr == `SDCC_RAW) begin
    next_raw = raw & ~wdata;
  end
  // set wins over a same-cycle clear
  if (fin_rx | fin_to | fin_nr) begin
    next_raw[`SDCC_R_DONE] = 1'b1;
  end
  if (fin_to) begin
    next_raw[`SDCC_R_RTO] = 1'b1;
  end
  if (fin_rx & bad_crc) begin
    next_raw[`SDCC_R_RCRC] = 1'b1;
  end
  if (fin_rx & bad_frm) begin
    next_raw[`SDCC_R_RERR] = 1'b1;
  end
  if (lock) begin
    next_raw[`SDCC_R_LQE] = 1'b1;
  end
end
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    raw <= `SDCC_RST32;
  end else begin
    raw <= next_raw;
  end
end
////////////////////////////////////////////////////////////
// register reads, data valid the cycle after the strobe
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    rdata <= `SDCC_RST32;
  end else if (rd_en) begin
    case (addr)
      `SDCC_CTRL: rdata <= ctrl;
      `SDCC_PWREN: rdata <= pwren;
      `SDCC_CLOCK_DIVIDER: rdata <= clock_divider;
      `SDCC_CLOCK_SOURCE_SELECT: rdata <= clock_source_select;
      `SDCC_CLKGATE: rdata <= clkgate;
      `SDCC_WIDTH: rdata <= width;
      `SDCC_ARG: rdata <= arg;
      `SDCC_CMD: rdata <= cmdw;
      `SDCC_RESP0: rdata <= resp0;
      `SDCC_RESP1: rdata <= resp1;
      `SDCC_RESP2: rdata <= resp2;
      `SDCC_RESP3: rdata <= resp3;
      `SDCC_RAW: rdata <= raw;
      `SDCC_STATUS: rdata <= {22'h0, data_busy | (pend & cmdw[`SDCC_C_UPD]),
        ~state[0], 8'h00};
      default: rdata <= `SDCC_RST32;
    endcase
  end else begin
    rdata <= `SDCC_RST32;
  end
end
endmodule
`default_nettype wire

// File: testbench/sdcc_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module sdcc_core_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic data_busy,
  input wire logic cmd_oe,
  input wire logic cclk_out,
  input wire logic [1:0] supply_sel,
  input wire logic power_en,
  input wire logic [1:0] bus_width
);
  logic upd_seen;
  logic cmd_seen;
  wire logic cmd_wr = wr_en && addr == 8'h2C && wdata[31];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upd_seen <= 1'b0;
      cmd_seen <= 1'b0;
    end else if (cmd_wr) begin
      upd_seen <= upd_seen | wdata[21];
      cmd_seen <= cmd_seen | ~wdata[21];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_unmapped_read: assert property (rd_en && addr == 8'hF0 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_busy: assert property (rd_en && addr == 8'h48 && data_busy |=> rdata[9])
    else $error("busy bit clear while data busy");
  a_width_map: assert property (wr_en && addr == 8'h18 |=>
    bus_width == ($past(wdata[16]) ? 2'h2 : {1'b0, $past(wdata[0])}))
    else $error("bus width not from width register");
  a_supply_map: assert property (wr_en && addr == 8'h00 |=> supply_sel == $past(wdata[1:0]))
    else $error("supply select not on pins");
  a_power_map: assert property (wr_en && addr == 8'h04 |=> power_en == $past(wdata[0]))
    else $error("power enable not on pin");
  a_clock_held: assert property (!upd_seen |-> !cclk_out)
    else $error("card clock ran before an update command");
  a_drive_launched: assert property ($rose(cmd_oe) |-> cmd_seen)
    else $error("command line driven without a launch");
  cover property (rd_en && addr == 8'h48 && data_busy);
  cover property ($rose(cmd_oe));
  cover property ($rose(cclk_out));
endmodule
bind sdcc_core sdcc_core_props u_props (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .data_busy(data_busy), .cmd_oe(cmd_oe), .cclk_out(cclk_out),
  .supply_sel(supply_sel), .power_en(power_en), .bus_width(bus_width));
`default_nettype wire

// File: testbench/sdcc_card.sv
`timescale 1ns/10ps
`default_nettype none
module sdcc_card (
  input wire logic cclk,
  input wire logic cmd_line,
  output logic oe,
  output logic bit_o
);
  logic reply_on = 1'b1;
  logic crc_bad = 1'b0;
  logic long_on = 1'b0;
  logic [47:0] rx = 48'h0;
  logic [135:0] tx = 136'h0;
  int n_bits = 48;
  function automatic [6:0] crc7(input logic [119:0] d, input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  initial begin
    oe = 1'b0;
    bit_o = 1'b1;
    forever begin
      @(posedge cclk);
      if (cmd_line === 1'b0 && !oe) begin
        // bits after the start bit: transmission, index, argument, crc, end
        rx = 48'h0;
        repeat (47) begin
          @(posedge cclk);
          rx = {rx[46:0], cmd_line};
        end
        if (reply_on) begin
          if (long_on) begin
            // long reply: fixed pattern, crc over the 120 bits after the first byte
            n_bits = 136;
            tx[135:8] = {8'h3F, 120'hF0E1D2C3B4A5968778695A4B3C2D1E};
            tx[7:0] = {crc7(tx[127:8], 120) ^ {6'h00, crc_bad}, 1'b1};
          end else begin
            n_bits = 48;
            tx[47:8] = {2'b00, rx[45:40], ~rx[39:8]};
            tx[7:0] = {crc7({80'h0, tx[47:8]}, 40) ^ {6'h00, crc_bad}, 1'b1};
          end
          repeat (2) @(negedge cclk);
          for (int i = n_bits - 1; i >= 0; i--) begin
            @(negedge cclk);
            oe = 1'b1;
            bit_o = tx[i];
          end
          @(negedge cclk);
          oe = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/sdcc_core_test.sv
`timescale 1ns/10ps
`default_nettype none
module sdcc_core_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic data_busy = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic cmd_out, cmd_oe, cclk_out, power_en, card_oe, card_bit;
  logic [1:0] supply_sel, bus_width;
  longint t0;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] wv[3] = '{32'h10001, 32'h1, 32'h0};
  logic [31:0] c_word[5] = '{32'h80002148, 32'h80002148, 32'h80002145, 32'h8000A000, 32'h800021C2};
  logic [31:0] c_arg[5] = '{32'h1AA, 32'h1AA, 32'h0, 32'h0, 32'h0};
  logic [31:0] c_raw[5] = '{32'h4, 32'h104, 32'h6, 32'h4, 32'h4};
  // reply on, bad crc, long reply
  logic [2:0] c_card[5] = '{3'b100, 3'b110, 3'b000, 3'b000, 3'b101};
  // command line has a pull-up when nobody drives it
  wire logic cmd_line = card_oe ? card_bit : (cmd_oe ? cmd_out : 1'b1);
  always #10 clk = ~clk;
  sdcc_core #(.RESP_TO(4)) u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .data_busy(data_busy), .cmd_in(cmd_line), .cmd_out(cmd_out),
    .cmd_oe(cmd_oe), .cclk_out(cclk_out), .supply_sel(supply_sel), .power_en(power_en), .bus_width(bus_width));
  sdcc_card u_card (.cclk(cclk_out), .cmd_line(cmd_line), .oe(card_oe), .bit_o(card_bit));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd = rdata;
  endtask
  task automatic wait_raw(input logic [31:0] m);
    for (int k = 0; k < 1000; k++) begin
      rdr(8'h44);
      if ((rd & m) !== 32'h0) break;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdr(8'h44);
    chk("raw status", 32'h0, rd);
    rdr(8'hF0);
    chk("unmapped", 32'h0, rd);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h1);
    chk("supply pins", 32'h7, {29'h0, power_en, supply_sel});
    for (int i = 0; i < 3; i++) begin
      wr(8'h18, wv[i]);
      chk("bus width", 32'(2 - i), {30'h0, bus_width});
    end
    // gate on, divider 2, then a clock-only update
    wr(8'h08, 32'h2);
    wr(8'h10, 32'h1);
    wr(8'h2C, 32'h80202000);
    repeat (3) @(posedge clk);
    rdr(8'h2C);
    chk("start cleared", 32'h0, rd & 32'h80000000);
    @(posedge cclk_out);
    t0 = $time;
    @(posedge cclk_out);
    chk("card clock period", 32'd80, 32'($time - t0));
    rdr(8'h44);
    chk("update done flag", 32'h0, rd);
    for (int i = 0; i < 5; i++) begin
      wr(8'h44, 32'hFFFFFFFF);
      {u_card.reply_on, u_card.crc_bad, u_card.long_on} = c_card[i];
      wr(8'h28, c_arg[i]);
      wr(8'h2C, c_word[i]);
      wait_raw(32'h6);
      rdr(8'h44);
      chk("raw status", c_raw[i], rd);
      chk("frame", {c_word[i][5:0], c_arg[i], 2'b11}, {u_card.rx[45:8], u_card.rx[46], u_card.rx[0]});
      rdr(8'h30);
      if (i == 0) chk("reply word", ~c_arg[i], rd);
      if (i == 4) chk("long reply low", u_card.tx[31:0], rd);
      rdr(8'h3C);
      if (i == 4) chk("long reply top", u_card.tx[127:96], rd);
    end
    wr(8'h44, 32'hFFFFFFFF);
    {u_card.reply_on, u_card.crc_bad, u_card.long_on} = 3'b100;
    @(posedge clk);
    data_busy <= 1'b1;
    wr(8'h2C, 32'h80002140);
    wr(8'h2C, 32'h80002141);
    rdr(8'h44);
    chk("lock error", 32'h1000, rd);
    rdr(8'h48);
    chk("status busy", 32'h200, rd & 32'h200);
    rdr(8'h2C);
    chk("held command", 32'h80000000, rd & 32'h8000003F);
    @(posedge clk);
    data_busy <= 1'b0;
    wait_raw(32'h6);
    rdr(8'h44);
    chk("sticky lock", 32'h1004, rd);
    tally_and_finish();
  end
endmodule
`default_nettype wire
